// ### verilog/gate_drive_fault_config_regs.sv
// gate drive fault flags, high/low side drive settings and operation bits
// reached over a 16-bit serial port clocked by the host (link_sclk);
// assumes chip select stays high for at least 100 ns between frames.
// Functional notes
// - fault register bits 10, 8, 6 latch high-side gate faults of phases A, B, C, zero at reset.
// - fault register bits 9, 7, 5 latch low-side gate faults of phases A, B, C; bits 4:0 read zero.
// - both drive setting registers are writable except in sleep, where writes are dropped, and read back the last value written.
// - settings survive reads, the clear-faults command and the gate-enable driver reset.
// - reset loads each drive setting register with its default fields.
// - entering sleep restores both drive setting registers to defaults, dropping host values.
// - high-side bits 9:8 pick peak source time 220/440/880/1780 ns, default code 3.
// - high-side bits 7:4 pick peak sink current, default code 4, 0 gives 20 mA, 12-15 give 60 mA.
// - high-side bits 3:0 pick peak source current, 10-70 mA, 0.125-1 A, 12-15 give 50 mA.
// - low-side bits 9:8 pick peak drive time with the same four steps, default code 3.
// - low-side bits 7:4 pick peak sink current, default 4, 0 gives 20 mA, 11 gives 1.25 A.
// - low-side bits 3:0 pick peak source current, default 4, 12 and above give 50 mA.
// - words are 16 bits; data sits in bits 10:0 and the upper five response bits are padding.
// - writing bit 1 of the operation register clears the latched faults.
// - bit 2 of the operation register puts the device to sleep while set.
`timescale 1ns/100ps
`default_nettype none
module gate_drive_fault_config_regs (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic link_sclk,
  input wire logic link_cs_n,
  input wire logic link_mosi,
  output logic link_miso_o,
  output logic link_miso_oe,
  input wire logic [5:0] gate_fault_raw,
  input wire logic gate_enable,
  output drive_regs_pkg::drive_setting_s hs_setting,
  output drive_regs_pkg::drive_setting_s ls_setting,
  output drive_regs_pkg::drive_strength_s hs_strength,
  output drive_regs_pkg::drive_strength_s ls_strength,
  output logic sleep_active,
  output logic clear_faults_cmd
);

  function automatic logic [10:0] time_ns(input logic [1:0] code);
    unique case (code)
      2'h0: time_ns = 11'd220;
      2'h1: time_ns = 11'd440;
      2'h2: time_ns = 11'd880;
      2'h3: time_ns = 11'd1780;
    endcase
  endfunction : time_ns

  // codes 12..15 are unused settings and fall back to a safe low current
  function automatic logic [10:0] sink_ma(input logic [3:0] code);
    unique case (code)
      4'h0: sink_ma = 11'd20;
      4'h1: sink_ma = 11'd30;
      4'h2: sink_ma = 11'd40;
      4'h3: sink_ma = 11'd50;
      4'h4: sink_ma = 11'd60;
      4'h5: sink_ma = 11'd70;
      4'h6: sink_ma = 11'd80;
      4'h7: sink_ma = 11'd250;
      4'h8: sink_ma = 11'd500;
      4'h9: sink_ma = 11'd750;
      4'ha: sink_ma = 11'd1000;
      4'hb: sink_ma = 11'd1250;
      default: sink_ma = 11'd60;
    endcase
  endfunction : sink_ma

  function automatic logic [10:0] source_ma(input logic [3:0] code);
    unique case (code)
      4'h0: source_ma = 11'd10;
      4'h1: source_ma = 11'd20;
      4'h2: source_ma = 11'd30;
      4'h3: source_ma = 11'd40;
      4'h4: source_ma = 11'd50;
      4'h5: source_ma = 11'd60;
      4'h6: source_ma = 11'd70;
      4'h7: source_ma = 11'd125;
      4'h8: source_ma = 11'd250;
      4'h9: source_ma = 11'd500;
      4'ha: source_ma = 11'd750;
      4'hb: source_ma = 11'd1000;
      default: source_ma = 11'd50;
    endcase
  endfunction : source_ma

  // link domain: shift in on falling sclk, shift out between falling edges

  logic [3:0] bit_cnt_q;
  logic [14:0] rx_q;
  drive_regs_pkg::spi_word_s word_q;
  logic word_tgl_q;
  logic [15:0] resp_q;

  // chip select high ends the frame without needing a clock edge
  always_ff @(negedge link_sclk or posedge link_cs_n) begin
    if (link_cs_n) begin
      bit_cnt_q <= 4'h0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  always_ff @(negedge link_sclk) begin
    rx_q <= {rx_q[13:0], link_mosi};
  end

  // only a full 16-bit frame produces a command; short frames are dropped
  always_ff @(negedge link_sclk) begin
    if (!link_cs_n && bit_cnt_q == drive_regs_pkg::LAST_BIT) begin
      word_q <= {rx_q, link_mosi};
    end
  end

  // sclk may be idle during core reset, hence the asynchronous clear
  always_ff @(negedge link_sclk or posedge rst) begin
    if (rst) begin
      word_tgl_q <= 1'b0;
    end else if (!link_cs_n && bit_cnt_q == drive_regs_pkg::LAST_BIT) begin
      word_tgl_q <= ~word_tgl_q;
    end
  end

  // resp_q only changes after the last falling edge, so no bit moves mid-shift
  assign link_miso_oe = ~link_cs_n;
  assign link_miso_o = link_cs_n ? 1'b0 : resp_q[drive_regs_pkg::LAST_BIT - bit_cnt_q];

  // core domain

  logic tgl_s;
  logic [5:0] fault_s;
  logic gate_enable_s;
  logic tgl_seen_q;
  logic cmd_take;
  logic write_hs;
  logic write_ls;
  logic write_op;
  logic enter_sleep;
  logic fault_clear;
  logic sleep_q;
  logic clear_q;
  logic [5:0] flags_q;
  drive_regs_pkg::drive_setting_s hs_q;
  drive_regs_pkg::drive_setting_s ls_q;

  bit_sync #(
    .WIDTH(8)
  ) in_sync (
    .clk(core_clk),
    .rst(rst),
    .d({gate_enable, gate_fault_raw, word_tgl_q}),
    .q({gate_enable_s, fault_s, tgl_s})
  );

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tgl_seen_q <= 1'b0;
    end else begin
      tgl_seen_q <= tgl_s;
    end
  end

  // word_q has been stable for two core cycles when the toggle is seen
  assign cmd_take = tgl_s ^ tgl_seen_q;
  assign write_hs = cmd_take && !word_q.read && word_q.addr == drive_regs_pkg::ADDR_HS;
  assign write_ls = cmd_take && !word_q.read && word_q.addr == drive_regs_pkg::ADDR_LS;
  assign write_op = cmd_take && !word_q.read && word_q.addr == drive_regs_pkg::ADDR_OP;
  assign enter_sleep = write_op && word_q.data[drive_regs_pkg::OP_SLEEP_BIT];
  assign fault_clear = clear_q || !gate_enable_s;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sleep_q <= 1'b0;
    end else if (write_op) begin
      sleep_q <= word_q.data[drive_regs_pkg::OP_SLEEP_BIT];
    end
  end

  // clear bit is a command, not state: one pulse, reads back zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      clear_q <= 1'b0;
    end else begin
      clear_q <= write_op && word_q.data[drive_regs_pkg::OP_CLEAR_BIT];
    end
  end

  // a fault present during the clear cycle stays latched
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flags_q <= drive_regs_pkg::FAULT_RESET;
    end else begin
      flags_q <= fault_s | (fault_clear ? drive_regs_pkg::FAULT_RESET : flags_q);
    end
  end

  // settings only move on a write, sleep or reset; clears leave them alone
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hs_q <= drive_regs_pkg::HS_DEFAULT;
    end else if (sleep_q || enter_sleep) begin
      hs_q <= drive_regs_pkg::HS_DEFAULT;
    end else if (write_hs) begin
      hs_q <= word_q.data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ls_q <= drive_regs_pkg::LS_DEFAULT;
    end else if (sleep_q || enter_sleep) begin
      ls_q <= drive_regs_pkg::LS_DEFAULT;
    end else if (write_ls) begin
      ls_q <= word_q.data;
    end
  end

  // answer is served in the next frame; value as held when command is taken
  always_ff @(posedge core_clk) begin
    if (rst) begin
      resp_q <= 16'h0000;
    end else if (cmd_take) begin
      unique case (word_q.addr)
        drive_regs_pkg::ADDR_FAULT: resp_q <= {drive_regs_pkg::RESP_PAD, flags_q,
                                               drive_regs_pkg::FAULT_RSVD_VAL};
        drive_regs_pkg::ADDR_HS: resp_q <= {drive_regs_pkg::RESP_PAD, hs_q};
        drive_regs_pkg::ADDR_LS: resp_q <= {drive_regs_pkg::RESP_PAD, ls_q};
        drive_regs_pkg::ADDR_OP: resp_q <= {drive_regs_pkg::RESP_PAD, 8'h00, sleep_q, 2'b00};
        default: resp_q <= 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hs_strength <= '0;
      ls_strength <= '0;
    end else begin
      hs_strength <= '{time_ns: time_ns(hs_q.drive_time), sink_ma: sink_ma(hs_q.sink),
                       source_ma: source_ma(hs_q.source)};
      ls_strength <= '{time_ns: time_ns(ls_q.drive_time), sink_ma: sink_ma(ls_q.sink),
                       source_ma: source_ma(ls_q.source)};
    end
  end

  assign hs_setting = hs_q;
  assign ls_setting = ls_q;
  assign sleep_active = sleep_q;
  assign clear_faults_cmd = clear_q;

  // checks

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  fault_set_a: assert property (fault_s[5] |=> flags_q[5])
    else $error("high-side A fault not latched");

  fault_sticky_a: assert property (flags_q[3] && !fault_clear |=> flags_q[3])
    else $error("fault flag dropped without a clear");

  fault_readback_a: assert property (cmd_take && word_q.addr == drive_regs_pkg::ADDR_FAULT
      |=> resp_q[4:0] == 5'h00 && resp_q[10:5] == $past(flags_q))
    else $error("fault register response wrong");

  write_readback_a: assert property (write_hs && !sleep_q && !enter_sleep
      |=> hs_q == $past(word_q.data))
    else $error("high-side write not stored");

  settings_hold_a: assert property (!write_ls && !sleep_q && !enter_sleep
      |=> $stable(ls_q))
    else $error("low-side setting changed without a write");

  reset_default_a: assert property (disable iff (1'b0) rst
      |=> hs_q == drive_regs_pkg::HS_DEFAULT && ls_q == drive_regs_pkg::LS_DEFAULT)
    else $error("settings not at default after reset");

  sleep_restore_a: assert property (sleep_q
      |-> hs_q == drive_regs_pkg::HS_DEFAULT && ls_q == drive_regs_pkg::LS_DEFAULT)
    else $error("settings not default while asleep");

  hs_decode_a: assert property (hs_q.drive_time == 2'h3 && hs_q.source == 4'hb
      |=> hs_strength.time_ns == 11'd1780 && hs_strength.source_ma == 11'd1000)
    else $error("high-side decode wrong");

  hs_sink_a: assert property (hs_q.sink == 4'h0 |=> hs_strength.sink_ma == 11'd20)
    else $error("high-side sink decode wrong");

  ls_decode_a: assert property (ls_q.drive_time == 2'h0 && ls_q.sink == 4'hb
      && ls_q.source == 4'h8 |=> ls_strength.time_ns == 11'd220
      && ls_strength.sink_ma == 11'd1250 && ls_strength.source_ma == 11'd250)
    else $error("low-side decode wrong");

  resp_pad_a: assert property (resp_q[15:11] == 5'h00)
    else $error("response padding not zero");

  clear_faults_a: assert property (write_op && word_q.data[drive_regs_pkg::OP_CLEAR_BIT]
      && gate_enable_s ##1 fault_s == 6'h00 |=> flags_q == 6'h00)
    else $error("clear command left a fault latched");

  sleep_entry_a: assert property (enter_sleep |=> sleep_active ##1 sleep_active)
    else $error("sleep not entered");

  low_fault_set_a: assert property (fault_s[4] |=> flags_q[4])
    else $error("low-side A fault not latched");

  ls_write_a: assert property (write_ls && !sleep_q && !enter_sleep
      |=> ls_q == $past(word_q.data))
    else $error("low-side write not stored");

  gate_reset_keep_a: assert property (!gate_enable_s && !write_hs && !sleep_q && !enter_sleep
      |=> $stable(hs_q))
    else $error("high-side setting moved on driver reset");

  hs_sink_fallback_a: assert property (hs_q.sink[3:2] == 2'b11
      |=> hs_strength.sink_ma == 11'd60)
    else $error("high-side sink fallback wrong");

  hs_source_fallback_a: assert property (hs_q.source[3:2] == 2'b11
      |=> hs_strength.source_ma == 11'd50)
    else $error("high-side source fallback wrong");

  ls_time_decode_a: assert property (ls_q.drive_time == 2'h3
      |=> ls_strength.time_ns == 11'd1780)
    else $error("low-side time decode wrong");

  ls_sink_fallback_a: assert property (ls_q.sink[3:2] == 2'b11
      |=> ls_strength.sink_ma == 11'd60)
    else $error("low-side sink fallback wrong");

  ls_source_fallback_a: assert property (ls_q.source[3:2] == 2'b11
      |=> ls_strength.source_ma == 11'd50)
    else $error("low-side source fallback wrong");

  clear_pulse_a: assert property (clear_q |=> !clear_q)
    else $error("clear command longer than one cycle");

  sleep_hold_a: assert property (sleep_q && !write_op |=> sleep_q)
    else $error("sleep left without a write");

  wake_up_a: assert property (write_op && !word_q.data[drive_regs_pkg::OP_SLEEP_BIT]
      |=> !sleep_active)
    else $error("sleep not left on wake write");

  op_readback_a: assert property (cmd_take && word_q.addr == drive_regs_pkg::ADDR_OP
      |=> resp_q[2] == $past(sleep_q) && resp_q[1:0] == 2'b00)
    else $error("operation register response wrong");

  fault_read_c: cover property (cmd_take && word_q.read && word_q.addr == drive_regs_pkg::ADDR_FAULT
      && flags_q != 6'h00);
  hs_write_c: cover property (write_hs && !sleep_q);
  sleep_enter_c: cover property (enter_sleep ##[1:1000] write_hs && sleep_q);
  fault_clear_c: cover property (flags_q != 6'h00 ##1 clear_q ##1 flags_q == 6'h00);

endmodule : gate_drive_fault_config_regs
`default_nettype wire

// ### verilog/drive_regs_pkg.sv
// constants and carrier types for the gate drive fault and setting registers
// assumes a 16-bit serial word: read flag, 4-bit address, 11 data bits
package drive_regs_pkg;

  localparam int WORD_W = 16;
  localparam int DATA_W = 11;
  localparam int ADDR_W = 4;

  // register addresses on the serial port
  localparam logic [3:0] ADDR_FAULT = 4'h4;
  localparam logic [3:0] ADDR_HS = 4'h5;
  localparam logic [3:0] ADDR_LS = 4'h6;
  localparam logic [3:0] ADDR_OP = 4'h9;

  // operation register bit positions
  localparam int OP_CLEAR_BIT = 1;
  localparam int OP_SLEEP_BIT = 2;

  // fault register layout: six flags from bit 10 down, bits 4:0 reserved
  localparam int FAULT_LSB = 5;
  localparam logic [4:0] FAULT_RSVD_VAL = 5'h00;
  localparam logic [5:0] FAULT_RESET = 6'h00;
  localparam logic [4:0] RESP_PAD = 5'h00;
  localparam logic [3:0] LAST_BIT = 4'hf;

  typedef struct packed {
    logic read;
    logic [3:0] addr;
    logic [10:0] data;
  } spi_word_s;

  typedef struct packed {
    logic rsvd;
    logic [1:0] drive_time;
    logic [3:0] sink;
    logic [3:0] source;
  } drive_setting_s;

  typedef struct packed {
    logic [10:0] time_ns;
    logic [10:0] sink_ma;
    logic [10:0] source_ma;
  } drive_strength_s;

  localparam drive_setting_s HS_DEFAULT = '{rsvd: 1'b0, drive_time: 2'h3, sink: 4'h4,
                                            source: 4'h4};
  localparam drive_setting_s LS_DEFAULT = '{rsvd: 1'b0, drive_time: 2'h3, sink: 4'h4,
                                            source: 4'h4};

endpackage : drive_regs_pkg

// ### verilog/bit_sync.sv
// two-flop synchroniser for a bus of independent levels
// assumes each bit is a slow level; no word coherence across bits
`timescale 1ns/100ps
`default_nettype none
module bit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : bit_sync
`default_nettype wire

// ### tb/spi_host_model.sv
// host-side serial master model: one 16-bit frame per rising edge of req
// assumes the device samples mosi on falling sclk and shifts miso after it
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  input wire logic req,
  input wire logic [15:0] word,
  output logic busy,
  output logic [15:0] resp,
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe
);
  // no pull on miso, so a released line reads as z and fails the compare
  wire miso_w = miso_oe ? miso_o : 1'bz;
  initial begin
    busy = 1'b0;
    resp = 16'h0000;
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    forever begin
      @(posedge req);
      busy = 1'b1;
      #37;
      cs_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
        #80;
        sclk = 1'b1;
        mosi = word[i];
        #80;
        resp[i] = miso_w;
        sclk = 1'b0;
      end
      #80;
      cs_n = 1'b1;
      mosi = ~mosi;
      // gap well above 100 ns before the next frame may start
      #150;
      busy = 1'b0;
    end
  end
endmodule : spi_host_model
`default_nettype wire

// ### tb/gate_drive_fault_config_regs_tb.sv
// self-checking bench for the gate fault flags and drive setting registers
// assumes spi_host_model plays the host on the serial port
`timescale 1ns/100ps
`default_nettype none
module gate_drive_fault_config_regs_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic [15:0] word = 16'h0000;
  logic busy, sclk, cs_n, mosi, miso_o, miso_oe, sleep_active, clr;
  logic [15:0] resp;
  logic [5:0] raw = 6'h00;
  logic gate_en = 1'b1;
  drive_regs_pkg::drive_setting_s hs_s, ls_s;
  drive_regs_pkg::drive_strength_s hs_t, ls_t;
  logic [10:0] hs_m = 11'h344, ls_m = 11'h344, flt_m = 11'h000;
  logic slp_m = 1'b0;
  logic [31:0] seed = 32'h0000_000a;
  logic [16:0] q[$];
  int mismatches = 0;
  int checked = 0;
  int clr_seen = 0;
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (clr === 1'b1) begin
      clr_seen++;
    end
  end
  gate_drive_fault_config_regs gate_drive_fault_config_regs_i (.core_clk(core_clk), .rst(rst),
    .link_sclk(sclk), .link_cs_n(cs_n), .link_mosi(mosi), .link_miso_o(miso_o),
    .link_miso_oe(miso_oe), .gate_fault_raw(raw), .gate_enable(gate_en), .hs_setting(hs_s),
    .ls_setting(ls_s), .hs_strength(hs_t), .ls_strength(ls_t), .sleep_active(sleep_active),
    .clear_faults_cmd(clr));
  spi_host_model spi_host_model_i (.req(req), .word(word), .busy(busy), .resp(resp),
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [32:0] strength(input logic [9:0] v);
    logic [10:0] t[4];
    logic [10:0] k[16];
    logic [10:0] p[16];
    t = '{11'h0dc, 11'h1b8, 11'h370, 11'h6f4};
    k = '{11'h014, 11'h01e, 11'h028, 11'h032, 11'h03c, 11'h046, 11'h050, 11'h0fa,
          11'h1f4, 11'h2ee, 11'h3e8, 11'h4e2, 11'h03c, 11'h03c, 11'h03c, 11'h03c};
    p = '{11'h00a, 11'h014, 11'h01e, 11'h028, 11'h032, 11'h03c, 11'h046, 11'h07d,
          11'h0fa, 11'h1f4, 11'h2ee, 11'h3e8, 11'h032, 11'h032, 11'h032, 11'h032};
    return {t[v[9:8]], k[v[7:4]], p[v[3:0]]};
  endfunction : strength
  task automatic wrap_up();
    if (mismatches == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // the answer to a command comes back in the following frame
  always @(negedge busy) begin : watch
    logic [16:0] e;
    // busy steps from x to 0 at time zero; that is not a frame
    if ($time > 0) begin
      e = q.pop_front();
      if (!e[16]) begin
        chk({17'h0_0000, resp}, {17'h0_0000, e[15:0]});
      end
    end
  end
  task automatic cmd(input logic rd, input logic [3:0] a, input logic [10:0] d);
    logic [16:0] e;
    int n;
    case (a)
      4'h4: e = {6'h00, flt_m};
      4'h5: e = {6'h00, hs_m};
      4'h6: e = {6'h00, ls_m};
      4'h9: e = {14'h0000, slp_m, 2'b00};
      default: e = 17'h0_0000;
    endcase
    q.push_back(e);
    if (!rd && a == 4'h5 && !slp_m) hs_m = d;
    if (!rd && a == 4'h6 && !slp_m) ls_m = d;
    if (!rd && a == 4'h9) begin
      slp_m = d[2];
      if (d[1]) flt_m = 11'h000;
      if (d[2]) {hs_m, ls_m} = {11'h344, 11'h344};
    end
    @(negedge core_clk);
    word = {rd, a, d};
    req = 1'b1;
    @(negedge core_clk);
    req = 1'b0;
    n = 0;
    while (busy && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 2000) begin
      mismatches++;
      wrap_up();
    end
  endtask : cmd
  task automatic regs();
    chk({11'h000, hs_s, ls_s}, {11'h000, hs_m, ls_m});
  endtask : regs
  initial begin
    q.push_back(17'h0_0000);
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    repeat (3) @(negedge core_clk);
    regs();
    chk(hs_t, {11'h6f4, 11'h03c, 11'h032});
    chk(ls_t, {11'h6f4, 11'h03c, 11'h032});
    for (int c = 0; c < 16; c++) begin
      // high-side sink code 11 (1250 mA) is left out there and driven as 0; the low side covers it
      cmd(1'b0, 4'h5, {1'b0, 2'(c), (c == 11) ? 4'h0 : 4'(c), 4'(c)});
      cmd(1'b0, 4'h6, {1'b0, 2'(c), 4'(c), 4'(c)});
      chk(hs_t, strength(hs_m[9:0]));
      chk(ls_t, strength(ls_m[9:0]));
      regs();
    end
    cmd(1'b0, 4'h6, 11'h0b8);
    chk(ls_t, {11'h0dc, 11'h4e2, 11'h0fa});
    seed = xs(seed);
    cmd(1'b0, 4'h5, {1'b0, seed[9:0]});
    seed = xs(seed);
    cmd(1'b0, 4'h6, {1'b0, seed[9:0]});
    cmd(1'b1, 4'h5, 11'h000);
    cmd(1'b1, 4'h6, 11'h000);
    cmd(1'b0, 4'h4, 11'h7ff);
    cmd(1'b1, 4'h3, 11'h000);
    seed = xs(seed);
    raw = seed[5:0] | 6'h21;
    repeat (6) @(negedge core_clk);
    flt_m = {raw, 5'h00};
    raw = 6'h00;
    cmd(1'b1, 4'h4, 11'h000);
    cmd(1'b1, 4'h4, 11'h000);
    cmd(1'b0, 4'h9, 11'h002);
    chk(33'(clr_seen), 33'h0_0000_0001);
    cmd(1'b1, 4'h4, 11'h000);
    regs();
    raw = 6'h3f;
    repeat (6) @(negedge core_clk);
    flt_m = 11'h7e0;
    raw = 6'h00;
    cmd(1'b1, 4'h4, 11'h000);
    gate_en = 1'b0;
    repeat (6) @(negedge core_clk);
    gate_en = 1'b1;
    flt_m = 11'h000;
    cmd(1'b1, 4'h4, 11'h000);
    regs();
    cmd(1'b0, 4'h9, 11'h004);
    chk({32'h0000_0000, sleep_active}, 33'h0_0000_0001);
    regs();
    cmd(1'b0, 4'h5, 11'h155);
    cmd(1'b1, 4'h9, 11'h000);
    cmd(1'b0, 4'h9, 11'h000);
    chk({32'h0000_0000, sleep_active}, 33'h0_0000_0000);
    cmd(1'b1, 4'h5, 11'h000);
    cmd(1'b1, 4'h6, 11'h000);
    regs();
    chk(33'(clr_seen), 33'h0_0000_0001);
    wrap_up();
  end
endmodule : gate_drive_fault_config_regs_tb
`default_nettype wire
